//--- pkg/sfio_pkg.sv
// ----------------------------------------------------------------
// Shared constants of the serial frame sequencer.
// ----------------------------------------------------------------
package sfio_pkg;

	// Clock rate and derived timing counts.
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned IDLE_TIME_NS = 1000;
	localparam int unsigned IDLE_CYCLES = IDLE_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned WAKE_LOBES = 3;
	localparam int unsigned PCLK_FREQ_KHZ = 6670;
	localparam int unsigned PCLK_DIV = (2000000 / (CLK_PERIOD_NS * PCLK_FREQ_KHZ) + 1) / 2;
	localparam int unsigned PCLK_HIGH = PCLK_DIV / 2;

	// Frame geometry inside the 21-bit shift register.
	localparam int unsigned FRAME_BITS = 21;
	localparam int unsigned LATCH_BITS = 19;
	localparam int unsigned SR_LOW_LSB = 3;
	localparam int unsigned SR_DPL = 11;
	localparam int unsigned SR_HIGH_LSB = 12;
	localparam int unsigned SR_DPH = 20;
	localparam int unsigned SR_LATCH_LSB = 2;

	// Start codes, written first-received bit leftmost.
	localparam logic [2:0] START_NORMAL = 3'h6;
	localparam logic [2:0] START_MAINT = 3'h5;

	// Register map, byte addresses.
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_LATCH = 4'h8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam int unsigned CTRL_MAINT_BIT = 0;
	localparam int unsigned STAT_STATE_LSB = 0;
	localparam int unsigned STAT_IDLE_BIT = 8;
	localparam int unsigned STAT_SUB_LSB = 12;
	localparam int unsigned STAT_TXEN_BIT = 16;

	// Sequencer state codes, digits A through E from left to right.
	typedef enum logic [4:0] {
		ST_PURGE = 5'h00,
		ST_RECV = 5'h10,
		ST_XFER = 5'h11,
		ST_GO0 = 5'h0e,
		ST_GO1 = 5'h16,
		ST_GO2 = 5'h1a,
		ST_GO3 = 5'h1c,
		ST_REPLY = 5'h1e,
		ST_TRANSMIT_STATE = 5'h1f
	} sfio_state_e;

endpackage : sfio_pkg

//--- verilog/sfio_bit_recover.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bit clock recovery from the two lobes of each bipolar bit.
// ----------------------------------------------------------------
module sfio_bit_recover (
	input wire logic i_clk, // System clock.
	input wire logic i_rst_n, // Asynchronous reset, active low.
	input wire logic i_pos, // Positive lobe present.
	input wire logic i_neg, // Negative lobe present.
	output logic o_pulse, // One-cycle recovered bit pulse.
	output logic o_bit, // Bit value valid with o_pulse.
	output logic o_lobe // Registered lobe activity.
);

	logic neg_flag;
	logic pos_flag;
	logic first_pos;
	logic fire;

	// Both lobes seen and the line quiet again closes the bit.
	assign fire = neg_flag && pos_flag && !i_pos && !i_neg;

	// Lobe flags; the close of a bit clears both for the next one.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			neg_flag <= 1'b0;
			pos_flag <= 1'b0;
			first_pos <= 1'b0;
		end else if (fire) begin
			neg_flag <= 1'b0;
			pos_flag <= 1'b0;
		end else begin
			if (i_neg) begin
				neg_flag <= 1'b1;
			end
			if (i_pos) begin
				pos_flag <= 1'b1;
			end
			// The lobe that opens the bit carries its value.
			if (!neg_flag && !pos_flag && (i_pos || i_neg)) begin
				first_pos <= i_pos;
			end
		end
	end

	// Pulse, value and activity all leave from flops.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pulse <= 1'b0;
			o_bit <= 1'b0;
			o_lobe <= 1'b0;
		end else begin
			o_pulse <= fire;
			o_lobe <= i_pos || i_neg;
			if (fire) begin
				o_bit <= first_pos;
			end
		end
	end

endmodule : sfio_bit_recover

//--- verilog/sfio_sequencer.sv
`timescale 1ns/1ps
// Function
// - Idle flag sets after about one microsecond without inbound line activity.
// - Idle timer leaves idle only after three incoming lobes.
// - First state clock while idle restarts sequencer; idle clears after first bit.
// - A free-running clock is provided to the peripheral controllers.
// - Active subchannel is detected and latched to pick the target controller.
// - Message bits shift in until the leading one reaches the end.
// - Two lobe flags make a shift pulse once both set and line quiet.
// - Reply's initial one goes out under the hold flop; the first transmit shift then clears hold.
// - Reply is clocked by incoming zeros; ends after twenty-one bits.
// - State lives in a five-bit register, digits A to E.
// - Restart enters receive if both halves are zero, else purge.
// - Purge ignores the message, lets zeros fill the register, sends nothing.
// - Leading one at the rightmost slot enters transfer and pulses the latch gate.
// - Transfer advances on code 110 with good parity, or 101 with any.
// - Go state code is chosen by latched subchannel.
// - Go drives target enable, reply select and parallel load.
// - Go moves to reply only when the target reports reply ready.
// - Reply pulses parity insertion and raises transmit enable.
// - Reply moves to transmit only when all target enables are off.
// - Transmit sends start code, then data and parity, shifting zeros in.
// - Scanner reply: low data bit while load window low clears that bit.
module sfio_sequencer (
	input wire logic i_clk, // System clock, 100 MHz.
	input wire logic i_rst_n, // Asynchronous reset, active low.
	input wire logic [3:0] i_sub_pos, // Positive lobe per subchannel.
	input wire logic [3:0] i_sub_neg, // Negative lobe per subchannel.
	input wire logic [15:0] i_reply_data0, // Reply data, controller 0.
	input wire logic [15:0] i_reply_data1, // Reply data, controller 1.
	input wire logic [15:0] i_reply_data2, // Reply data, controller 2.
	input wire logic [15:0] i_reply_data3, // Reply data, controller 3.
	input wire logic i_reply_ready0_n, // Reply ready, controller 0.
	input wire logic i_reply_ready1_n, // Reply ready, controller 1.
	input wire logic i_reply_ready2_n, // Reply ready, controller 2.
	input wire logic i_reply_ready3_n, // Reply ready, controller 3.
	input wire logic i_scan_load_window0_n, // Scanner 0 load window.
	input wire logic i_scan_load_window3_n, // Scanner 3 load window.
	input wire logic [3:0] i_avs_address, // Avalon byte address.
	input wire logic i_avs_read, // Avalon read.
	input wire logic i_avs_write, // Avalon write.
	input wire logic [31:0] i_avs_writedata, // Avalon write data.
	input wire logic [3:0] i_avs_byteenable, // Avalon byte enables.
	output logic [31:0] o_avs_readdata, // Avalon read data.
	output logic o_avs_waitrequest, // Avalon wait request.
	output logic o_peripheral_sequencing_clock, // Clock to controllers.
	output logic o_target0_enable_n, // Controller 0 enable.
	output logic o_target1_enable_n, // Controller 1 enable.
	output logic o_target2_enable_n, // Controller 2 enable.
	output logic o_target3_enable_n, // Controller 3 enable.
	output logic o_reply_select0_n, // Reply selector 0 enable.
	output logic o_reply_select1_n, // Reply selector 1 enable.
	output logic o_reply_select2_n, // Reply selector 2 enable.
	output logic o_reply_select3_n, // Reply selector 3 enable.
	output logic o_reply_parallel_load, // Reply parallel load strobe.
	output logic o_parity_insert_strobe, // Parity insertion pulse.
	output logic o_latch_transfer_gate_n, // Latch transfer pulse.
	output logic [18:0] o_latch_data, // Latched message to data bus.
	output logic o_tx_enable_n, // Transmit enable.
	output logic o_reply_serial_out, // Reply bit to the line driver.
	output logic o_reply_bit_strobe // One-cycle strobe per reply bit.
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// Odd parity across a nine-bit half holds when the XOR is one.
	function automatic logic half_ok(input logic [8:0] v);
		half_ok = ^v;
	endfunction : half_ok

	// Places sixteen data bits into their shift register slots.
	function automatic logic [17:0] place(input logic [15:0] d);
		place = {1'b0, d[15:8], 1'b0, d[7:0]};
	endfunction : place

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	sfio_pkg::sfio_state_e state;
	sfio_pkg::sfio_state_e prev_state;
	sfio_pkg::sfio_state_e go_state;
	logic [20:0] sr;
	logic pulse;
	logic rx_bit;
	logic lobe;
	logic lobe_d;
	logic [6:0] quiet_cnt;
	logic [1:0] lobe_cnt;
	logic timer_on;
	logic idle_flag;
	logic restart;
	logic [1:0] active_sub;
	logic [1:0] sub_latch;
	logic halt;
	logic shift_ok;
	logic [2:0] code;
	logic advance;
	logic ready_n;
	logic [15:0] sel_data;
	logic scanner;
	logic window_n;
	logic enter_reply;
	logic tx_en;
	logic hold_n;
	logic tx_data;
	logic [4:0] tx_cnt;
	logic [3:0] pclk_cnt;
	logic [31:0] ctrl;
	logic req;

	// ----------------------------------------------------------------
	// Receiver
	// ----------------------------------------------------------------

	// All four subchannels share one recovery; only one carries a frame.
	sfio_bit_recover u_rec (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_pos(|i_sub_pos),
		.i_neg(|i_sub_neg),
		.o_pulse(pulse),
		.o_bit(rx_bit),
		.o_lobe(lobe)
	);

	// Quiet timer; an idle line is the only end-of-exchange marker.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			quiet_cnt <= 7'h00;
			lobe_cnt <= 2'h0;
			timer_on <= 1'b1;
			lobe_d <= 1'b0;
		end else begin
			lobe_d <= lobe;
			if (lobe) begin
				quiet_cnt <= 7'h00;
			end else if (quiet_cnt != 7'(sfio_pkg::IDLE_CYCLES - 1)) begin
				quiet_cnt <= quiet_cnt + 7'h01;
			end else begin
				timer_on <= 1'b1;
				lobe_cnt <= 2'h0;
			end
			// A glitch of one or two lobes must not wake the receiver.
			if (timer_on && lobe && !lobe_d) begin
				if (lobe_cnt == 2'(sfio_pkg::WAKE_LOBES - 1)) begin
					timer_on <= 1'b0;
				end else begin
					lobe_cnt <= lobe_cnt + 2'h1;
				end
			end
		end
	end

	// Idle flag: set by the timer's turn-on, cleared by the first bit's pulse.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			idle_flag <= 1'b1;
		end else if (!timer_on && !lobe && quiet_cnt == 7'(sfio_pkg::IDLE_CYCLES - 1)) begin
			idle_flag <= 1'b1;
		end else if (pulse) begin
			idle_flag <= 1'b0;
		end
	end

	assign restart = pulse && idle_flag;

	// The subchannel that last showed a lobe is the active one.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			active_sub <= 2'h0;
		end else begin
			for (int k = 0; k < 4; k++) begin
				if (i_sub_pos[k] || i_sub_neg[k]) begin
					active_sub <= 2'(k);
				end
			end
		end
	end

	// Peripheral clock by division; 15 cycles give 6.67 MHz.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pclk_cnt <= 4'h0;
			o_peripheral_sequencing_clock <= 1'b0;
		end else begin
			pclk_cnt <= (pclk_cnt == 4'(sfio_pkg::PCLK_DIV - 1)) ? 4'h0 : pclk_cnt + 4'h1;
			o_peripheral_sequencing_clock <= pclk_cnt < 4'(sfio_pkg::PCLK_HIGH);
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------

	// Start code read first-received bit leftmost.
	assign code = {sr[0], sr[1], sr[2]};
	assign advance = (code == sfio_pkg::START_NORMAL && half_ok(sr[11:3]) && half_ok(sr[20:12]))
		|| (code == sfio_pkg::START_MAINT && ctrl[sfio_pkg::CTRL_MAINT_BIT]);

	// Selections by the latched subchannel.
	always_comb begin
		unique case (sub_latch)
			2'h0: begin
				go_state = sfio_pkg::ST_GO0;
				ready_n = i_reply_ready0_n;
				sel_data = i_reply_data0;
			end
			2'h1: begin
				go_state = sfio_pkg::ST_GO1;
				ready_n = i_reply_ready1_n;
				sel_data = i_reply_data1;
			end
			2'h2: begin
				go_state = sfio_pkg::ST_GO2;
				ready_n = i_reply_ready2_n;
				sel_data = i_reply_data2;
			end
			2'h3: begin
				go_state = sfio_pkg::ST_GO3;
				ready_n = i_reply_ready3_n;
				sel_data = i_reply_data3;
			end
		endcase
	end

	assign scanner = sub_latch == 2'h0 || sub_latch == 2'h3;
	assign window_n = (sub_latch == 2'h0) ? i_scan_load_window0_n : i_scan_load_window3_n;

	// Shifting stops once the leading one sits at the end, until transmit.
	assign halt = (state == sfio_pkg::ST_RECV && sr[0]) || (state != sfio_pkg::ST_RECV
		&& state != sfio_pkg::ST_PURGE && state != sfio_pkg::ST_TRANSMIT_STATE);
	assign shift_ok = pulse && (!halt || restart);
	assign enter_reply = pulse && state == go_state && !ready_n;

	// State register, clocked by recovered state clock pulses.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= sfio_pkg::ST_PURGE;
			sub_latch <= 2'h0;
		end else if (restart) begin
			sub_latch <= active_sub;
			if (sr[20:12] == 9'h000 && sr[11:3] == 9'h000) begin
				state <= sfio_pkg::ST_RECV;
			end else begin
				state <= sfio_pkg::ST_PURGE;
			end
		end else if (pulse) begin
			unique case (state)
				sfio_pkg::ST_PURGE: state <= sfio_pkg::ST_PURGE;
				sfio_pkg::ST_RECV: state <= sr[0] ? sfio_pkg::ST_XFER : sfio_pkg::ST_RECV;
				sfio_pkg::ST_XFER: state <= advance ? go_state : sfio_pkg::ST_XFER;
				sfio_pkg::ST_GO0, sfio_pkg::ST_GO1, sfio_pkg::ST_GO2, sfio_pkg::ST_GO3: begin
					state <= !ready_n ? sfio_pkg::ST_REPLY : state;
				end
				sfio_pkg::ST_REPLY: begin
					if (o_target0_enable_n && o_target1_enable_n && o_target2_enable_n && o_target3_enable_n) begin
						state <= sfio_pkg::ST_TRANSMIT_STATE;
					end
				end
				sfio_pkg::ST_TRANSMIT_STATE: state <= sfio_pkg::ST_TRANSMIT_STATE;
				default: state <= sfio_pkg::ST_PURGE;
			endcase
		end
	end

	// Shift register: serial in, parallel reply load, parity insert.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sr <= 21'h000000;
		end else if (shift_ok) begin
			sr <= {rx_bit, sr[20:1]};
		end else if (enter_reply) begin
			sr[sfio_pkg::SR_DPL] <= ~^sr[10:3];
			sr[sfio_pkg::SR_DPH] <= ~^sr[19:12];
			sr[0] <= sfio_pkg::START_NORMAL[2];
			sr[1] <= sfio_pkg::START_NORMAL[1];
			sr[2] <= sfio_pkg::START_NORMAL[0];
		end else if (pulse && state == sfio_pkg::ST_XFER && advance) begin
			// Scanner replies can only clear bits, so they start from ones.
			sr[20:3] <= scanner ? place(16'hffff) : place(sel_data);
		end else if (state == go_state && !scanner) begin
			sr[20:3] <= place(sel_data);
		end else if (state == go_state && !window_n) begin
			sr[20:3] <= sr[20:3] & place(sel_data);
		end
	end

	// Latch and transfer gate on entry to transfer.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_latch_data <= 19'h00000;
			o_latch_transfer_gate_n <= 1'b1;
		end else begin
			o_latch_transfer_gate_n <= !(state == sfio_pkg::ST_XFER && prev_state == sfio_pkg::ST_RECV);
			if (state == sfio_pkg::ST_XFER && prev_state == sfio_pkg::ST_RECV) begin
				o_latch_data <= sr[20:sfio_pkg::SR_LATCH_LSB];
			end
		end
	end

	// Decoded controls; all registered so the pins are glitch free.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prev_state <= sfio_pkg::ST_PURGE;
			o_target0_enable_n <= 1'b1;
			o_target1_enable_n <= 1'b1;
			o_target2_enable_n <= 1'b1;
			o_target3_enable_n <= 1'b1;
			o_reply_select0_n <= 1'b1;
			o_reply_select1_n <= 1'b1;
			o_reply_select2_n <= 1'b1;
			o_reply_select3_n <= 1'b1;
			o_reply_parallel_load <= 1'b0;
			o_parity_insert_strobe <= 1'b0;
		end else begin
			prev_state <= state;
			o_target0_enable_n <= state != sfio_pkg::ST_GO0;
			o_target1_enable_n <= state != sfio_pkg::ST_GO1;
			o_target2_enable_n <= state != sfio_pkg::ST_GO2;
			o_target3_enable_n <= state != sfio_pkg::ST_GO3;
			o_reply_select0_n <= state != sfio_pkg::ST_GO0;
			o_reply_select1_n <= state != sfio_pkg::ST_GO1;
			o_reply_select2_n <= state != sfio_pkg::ST_GO2;
			o_reply_select3_n <= state != sfio_pkg::ST_GO3;
			o_reply_parallel_load <= state == go_state;
			o_parity_insert_strobe <= enter_reply;
		end
	end

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------

	// Reply bits leave one per incoming zero; the hold flop covers the first.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tx_en <= 1'b0;
			hold_n <= 1'b1;
			tx_data <= 1'b0;
			tx_cnt <= 5'h00;
			o_tx_enable_n <= 1'b1;
			o_reply_serial_out <= 1'b0;
			o_reply_bit_strobe <= 1'b0;
		end else begin
			o_reply_bit_strobe <= 1'b0;
			if (restart) begin
				tx_en <= 1'b0;
				o_tx_enable_n <= 1'b1;
				hold_n <= 1'b1;
			end else if (enter_reply) begin
				tx_en <= 1'b1;
				o_tx_enable_n <= 1'b0;
				hold_n <= 1'b0;
				tx_data <= 1'b1;
				tx_cnt <= 5'h00;
			end else if (shift_ok && tx_en && state == sfio_pkg::ST_TRANSMIT_STATE) begin
				o_reply_serial_out <= tx_data;
				o_reply_bit_strobe <= 1'b1;
				tx_data <= sr[1];
				hold_n <= 1'b1;
				tx_cnt <= tx_cnt + 5'h01;
				if (tx_cnt == 5'(sfio_pkg::FRAME_BITS - 1)) begin
					tx_en <= 1'b0;
					o_tx_enable_n <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Avalon-MM slave
	// ----------------------------------------------------------------

	// Fixed one wait state: every request is answered on its second cycle.
	assign req = i_avs_read || i_avs_write;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata <= 32'h0000_0000;
		end else begin
			o_avs_waitrequest <= !(req && o_avs_waitrequest);
			if (i_avs_read && o_avs_waitrequest) begin
				unique case (i_avs_address)
					sfio_pkg::REG_CTRL: o_avs_readdata <= ctrl;
					sfio_pkg::REG_STATUS: o_avs_readdata <= {15'h0000, tx_en, 2'h0, sub_latch, 3'h0,
						idle_flag, 3'h0, state};
					sfio_pkg::REG_LATCH: o_avs_readdata <= {13'h0000, o_latch_data};
					default: o_avs_readdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Control register; only the maintenance-accept bit is implemented.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl <= sfio_pkg::CTRL_RESET;
		end else if (i_avs_write && !o_avs_waitrequest && i_avs_address == sfio_pkg::REG_CTRL
			&& i_avs_byteenable[0]) begin
			ctrl <= {31'h0000_0000, i_avs_writedata[sfio_pkg::CTRL_MAINT_BIT]};
		end
	end

endmodule : sfio_sequencer

//--- bench/sfio_seq_asserts.sv
`timescale 1ns/1ps
// ------------------------------------------------
// Port properties of the frame sequencer.
// ------------------------------------------------
module sfio_seq_asserts (
	input wire logic i_clk, // Clock.
	input wire logic i_rst_n, // Reset, active low.
	input wire logic o_peripheral_sequencing_clock, // Controller clock.
	input wire logic o_target0_enable_n, // Enable 0.
	input wire logic o_target1_enable_n, // Enable 1.
	input wire logic o_target2_enable_n, // Enable 2.
	input wire logic o_target3_enable_n, // Enable 3.
	input wire logic o_reply_parallel_load, // Reply load.
	input wire logic o_parity_insert_strobe, // Parity strobe.
	input wire logic o_latch_transfer_gate_n, // Latch gate.
	input wire logic [18:0] o_latch_data, // Latch.
	input wire logic o_tx_enable_n, // Transmit enable.
	input wire logic o_reply_serial_out, // Reply bit.
	input wire logic o_reply_bit_strobe // Reply bit strobe.
);
	logic [3:0] en_n;
	logic [4:0] sent;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	// Enables gathered so the one-hot checks read simply.
	assign en_n = {o_target3_enable_n, o_target2_enable_n, o_target1_enable_n, o_target0_enable_n};

	// Reply bits sent in this transmit period, so a runaway transmitter is caught.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sent <= 5'h00;
		end else if (o_tx_enable_n) begin
			sent <= 5'h00;
		end else if (o_reply_bit_strobe) begin
			sent <= sent + 5'h01;
		end
	end

	// The two phases of the controller clock.
	sequence pclk_low_s;
		(!o_peripheral_sequencing_clock) [*8];
	endsequence
	sequence pclk_high_s;
		o_peripheral_sequencing_clock [*7];
	endsequence

	pclk_period_a: assert property ($fell(o_peripheral_sequencing_clock) |-> pclk_low_s ##1 pclk_high_s)
		else $error("Controller clock phases are wrong.");
	one_target_a: assert property ($countones(~en_n) <= 1 && o_reply_parallel_load == !(&en_n))
		else $error("Target enables or reply load disagree.");
	gate_pulse_a: assert property ($fell(o_latch_transfer_gate_n) |=> o_latch_transfer_gate_n)
		else $error("Latch gate is longer than one cycle.");
	latch_hold_a: assert property (!$stable(o_latch_data) |-> !o_latch_transfer_gate_n || !$past(o_latch_transfer_gate_n))
		else $error("Latch changed without the gate.");
	reply_entry_a: assert property ($rose(o_parity_insert_strobe) |-> $fell(o_tx_enable_n) ##1 $rose(&en_n) && !o_parity_insert_strobe)
		else $error("Reply entry strobes are wrong.");
	transmit_state_gate_a: assert property (o_reply_bit_strobe |-> &en_n && !$past(o_tx_enable_n))
		else $error("Reply bit sent with a target enabled.");
	first_one_a: assert property (o_reply_bit_strobe && sent == 5'h00 && !o_tx_enable_n |-> o_reply_serial_out)
		else $error("First reply bit is not one.");
	bit_limit_a: assert property (sent <= 5'd21)
		else $error("More than 21 reply bits sent.");
	tx_end_a: assert property (o_reply_bit_strobe && sent == 5'd20 |-> ##[0:2] o_tx_enable_n)
		else $error("Transmit enable stays after the last bit.");
endmodule : sfio_seq_asserts

bind sfio_sequencer sfio_seq_asserts u_sfio_seq_asserts (.*);

//--- bench/sfio_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------
// Host line driver and the four peripheral controllers.
// ------------------------------------------------
module sfio_host_model (
	input wire logic i_clk, // Clock.
	input wire logic i_tx_strobe, // Reply bit strobe.
	input wire logic i_tx_bit, // Reply bit.
	input wire logic [3:0] i_enable_n, // Controller enables.
	output logic [3:0] o_pos = 4'h0, // Positive lobes.
	output logic [3:0] o_neg = 4'h0, // Negative lobes.
	output logic [3:0] o_ready_n // Controller reply ready.
);
	logic [20:0] reply = 21'h000000;
	int rcount = 0;
	logic [2:0] en_d [4] = '{default: 3'h0};

	// One symbol: lobe order gives the bit, then a quiet gap so the flags can close.
	task automatic send_bit(input logic [1:0] sub, input logic b);
		@(posedge i_clk);
		o_pos <= 4'(b) << sub;
		o_neg <= 4'(!b) << sub;
		repeat (2) @(posedge i_clk);
		o_pos <= 4'(!b) << sub;
		o_neg <= 4'(b) << sub;
		repeat (2) @(posedge i_clk);
		o_pos <= 4'h0;
		o_neg <= 4'h0;
		repeat (2) @(posedge i_clk);
	endtask : send_bit

	// A message, then zeros: a fixed count, or until the reply is in, then silence.
	task automatic send_msg(input logic [1:0] sub, input logic [20:0] msg, input int zeros);
		int n;
		rcount = 0;
		for (n = 0; n < 21; n++) begin
			send_bit(sub, msg[n]);
		end
		n = 0;
		while (zeros > 0 ? n < zeros : (rcount < 21 && n < 40)) begin
			send_bit(sub, 1'b0);
			n++;
		end
		repeat (150) @(posedge i_clk);
	endtask : send_msg

	// Collects reply bits; the count runs on so surplus bits show.
	always @(posedge i_clk) begin
		if (i_tx_strobe) begin
			if (rcount < 21) begin
				reply[rcount] = i_tx_bit;
			end
			rcount++;
		end
	end

	// A controller answers three cycles after its enable and lets go with it.
	always @(posedge i_clk) begin
		for (int k = 0; k < 4; k++) begin
			en_d[k] <= {en_d[k][1:0], !i_enable_n[k]};
		end
	end
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			o_ready_n[k] = !(en_d[k][2] && !i_enable_n[k]);
		end
	end
endmodule : sfio_host_model

//--- bench/testbench.sv
`timescale 1ns/1ps
// ------------------------------------------------
// Self-checking bench of the frame sequencer.
// ------------------------------------------------
module testbench;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [3:0] pos;
	logic [3:0] neg;
	logic [3:0] rdy_n;
	logic [3:0] en_n;
	logic [15:0] rdat [4] = '{default: 16'h0000};
	logic win0_n = 1'b0;
	logic win3_n = 1'b1;
	logic [3:0] addr = 4'h0;
	logic rd_req = 1'b0;
	logic wr_req = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] be = 4'h0;
	logic [31:0] avs_q;
	logic avs_wait;
	logic [18:0] latch;
	logic tx_en_n;
	logic strobe;
	logic sout;
	logic [31:0] rd;
	logic [20:0] m;
	logic [15:0] d;
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;

	// Clock at 100 MHz.
	always #5 i_clk = ~i_clk;

	// Design under test; strobes left open here are watched by the checker.
	sfio_sequencer u_sfio_sequencer (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sub_pos(pos), .i_sub_neg(neg),
		.i_reply_data0(rdat[0]), .i_reply_data1(rdat[1]), .i_reply_data2(rdat[2]), .i_reply_data3(rdat[3]),
		.i_reply_ready0_n(rdy_n[0]), .i_reply_ready1_n(rdy_n[1]), .i_reply_ready2_n(rdy_n[2]),
		.i_reply_ready3_n(rdy_n[3]), .i_scan_load_window0_n(win0_n), .i_scan_load_window3_n(win3_n),
		.i_avs_address(addr), .i_avs_read(rd_req), .i_avs_write(wr_req), .i_avs_writedata(wdata),
		.i_avs_byteenable(be), .o_avs_readdata(avs_q), .o_avs_waitrequest(avs_wait),
		.o_peripheral_sequencing_clock(), .o_target0_enable_n(en_n[0]), .o_target1_enable_n(en_n[1]),
		.o_target2_enable_n(en_n[2]), .o_target3_enable_n(en_n[3]), .o_reply_select0_n(),
		.o_reply_select1_n(), .o_reply_select2_n(), .o_reply_select3_n(), .o_reply_parallel_load(),
		.o_parity_insert_strobe(), .o_latch_transfer_gate_n(), .o_latch_data(latch),
		.o_tx_enable_n(tx_en_n), .o_reply_serial_out(sout), .o_reply_bit_strobe(strobe)
	);

	sfio_host_model u_sfio_host_model (
		.i_clk(i_clk), .i_tx_strobe(strobe), .i_tx_bit(sout), .i_enable_n(en_n),
		.o_pos(pos), .o_neg(neg), .o_ready_n(rdy_n)
	);

	// A 21-bit frame, first bit in bit 0, odd parity over each half.
	function automatic logic [20:0] frame(input logic [15:0] dat, input logic [2:0] code);
		return {~^dat[15:8], dat[15:8], ~^dat[7:0], dat[7:0], code};
	endfunction : frame

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// One bus access; the request holds until waitrequest is seen low.
	task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] q);
		@(posedge i_clk);
		rd_req <= !wr;
		wr_req <= wr;
		addr <= a;
		wdata <= wd;
		be <= 4'hf;
		do begin
			@(posedge i_clk);
		end while (avs_wait !== 1'b0);
		q = avs_q;
		rd_req <= 1'b0;
		wr_req <= 1'b0;
	endtask : avs

	// One message; a full reply is compared bit for bit, none means zeros only.
	task automatic run_msg(input logic [1:0] sub, input logic [20:0] msg, input int nrep, input logic [20:0] exp);
		u_sfio_host_model.send_msg(sub, msg, nrep == 21 ? 0 : 30);
		check(32'(u_sfio_host_model.rcount), 32'(nrep));
		if (nrep == 21) begin
			check(32'(u_sfio_host_model.reply), 32'(exp));
		end
	endtask : run_msg

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done

	// A hang is cut short well past the expected run of about 4000 cycles.
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			test_done();
		end
	end

	initial begin
		repeat (8) @(posedge i_clk);
		i_rst_n <= 1'b1;
		avs(1'b0, 4'h0, 32'h0, rd);
		check(rd, sfio_pkg::CTRL_RESET);
		avs(1'b0, 4'h4, 32'h0, rd);
		check(rd, 32'h0000_0100);
		avs(1'b1, 4'hc, 32'hffff_ffff, rd);
		avs(1'b0, 4'hc, 32'h0, rd);
		check(rd, 32'h0000_0000);
		// Every subchannel in turn; scanner 3 with its window shut returns all ones.
		for (int k = 0; k < 4; k++) begin
			d = 16'hc3a5 ^ 16'(k * 16'h0f11);
			rdat[k] <= d;
			m = frame(16'h9c41 ^ 16'(k * 16'h1111), 3'b011);
			run_msg(2'(k), m, 21, frame((k == 3) ? 16'hffff : d, 3'b011));
			check(32'(latch), 32'(m[20:2]));
			check(32'(tx_en_n), 32'h1);
			avs(1'b0, 4'h4, 32'h0, rd);
			check(rd, 32'h0000_011f | 32'(k << 12));
		end
		// Maintenance code passes with bad parity while enabled.
		m = frame(16'h0ff0, 3'b101) ^ 21'h000800;
		run_msg(2'd2, m, 21, frame(rdat[2], 3'b011));
		check(32'(latch), 32'(m[20:2]));
		// With maintenance refused the sequencer waits in transfer.
		avs(1'b1, 4'h0, 32'h0, rd);
		run_msg(2'd1, m, 0, 21'h0);
		avs(1'b0, 4'h4, 32'h0, rd);
		check(rd, 32'h0000_1111);
		// The leftover frame forces a purge; the retry then goes through.
		win3_n <= 1'b0;
		m = frame(16'h3c5a, 3'b011);
		run_msg(2'd3, m, 0, 21'h0);
		avs(1'b0, 4'h4, 32'h0, rd);
		check(32'(rd[4:0]), 32'h0);
		run_msg(2'd3, m, 21, frame(rdat[3], 3'b011));
		check(32'(latch), 32'(m[20:2]));
		test_done();
	end
endmodule : testbench
